/* File: design/cdf_pkg.sv */
// shared constants for the chopper decay and fault control block
package cdf_pkg;
  // one chopping period in oscillator clocks
  localparam int unsigned CHOP_PERIOD_CLK = 16;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'hF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // fixed mixed-decay split: fast decay for the first slots of the decay part
  localparam logic [CNT_W-1:0] MIXED_DECAY_FAST_SLOTS = 4'h4;
  // step-resolution code that selects standby
  localparam logic [2:0] STEP_RES_STANDBY = 3'h0;
  // switch vector order: {high_side_first, high_side_second, low_side_first, low_side_second}
  localparam logic [3:0] SW_OFF = 4'h0;
  localparam logic [3:0] SW_CHARGE_FWD = 4'h9;
  localparam logic [3:0] SW_FAST_FWD = 4'h6;
  localparam logic [3:0] SW_SLOW = 4'h3;
  localparam logic [3:0] SW_CHARGE_REV = 4'h6;
  localparam logic [3:0] SW_FAST_REV = 4'h9;

  typedef enum logic [1:0] {
    CDF_MODE_OFF,
    CDF_MODE_CHARGE,
    CDF_MODE_SLOW,
    CDF_MODE_FAST
  } cdf_mode_t;

  // bridge pattern for a mode and current direction
  function automatic logic [3:0] cdf_pattern(input cdf_mode_t m, input logic fwd);
    case (m)
      CDF_MODE_CHARGE: cdf_pattern = fwd ? SW_CHARGE_FWD : SW_CHARGE_REV;
      CDF_MODE_SLOW: cdf_pattern = SW_SLOW;
      CDF_MODE_FAST: cdf_pattern = fwd ? SW_FAST_FWD : SW_FAST_REV;
      default: cdf_pattern = SW_OFF;
    endcase
  endfunction : cdf_pattern
endpackage : cdf_pkg

/* File: design/cdf_sync.sv */
// three-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module cdf_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_r, s2_r, s3_r, held_r;
  logic [W-1:0] s1_nxt, s2_nxt, s3_nxt, held_nxt;

  // a change counts once stages two and three agree; stage one feeds only stage two
  always_comb begin
    s1_nxt = async_i;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    held_nxt = held_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        held_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      held_r <= '0;
    end else if (ce_i) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      held_r <= held_nxt;
    end
  end

  assign sync_o = held_r;
endmodule : cdf_sync
`default_nettype wire

/* File: design/cdf_period.sv */
// chopping period counter on the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module cdf_period (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  output logic [cdf_pkg::CNT_W-1:0] cnt_o,
  output logic wrap_o
);
  logic [cdf_pkg::CNT_W-1:0] cnt_r, cnt_nxt;

  // counter halts at zero while the oscillator is stopped
  always_comb begin
    if (!run_i) begin
      cnt_nxt = cdf_pkg::CNT_ZERO;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= cdf_pkg::CNT_ZERO;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cnt_o = cnt_r;
  assign wrap_o = run_i && (cnt_r == cdf_pkg::CNT_LAST);
endmodule : cdf_period
`default_nettype wire

/* File: design/cdf_chopper.sv */
// constant-current chopper with decay sequencing and open-drain fault flag
`timescale 1ns/1ps
`default_nettype none
module cdf_chopper (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] step_resolution_select_i,
  input wire logic current_fwd_i,
  input wire logic current_target_threshold_i,
  input wire logic thermal_shutdown_i,
  input wire logic overcurrent_shutdown_i,
  output logic high_side_first_o,
  output logic high_side_second_o,
  output logic low_side_first_o,
  output logic low_side_second_o,
  output logic fault_flag_out_o,
  output logic fault_flag_out_oe_n_o,
  output logic [1:0] mode_o
);
  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [6:0] raw_in, syn_in;
  assign raw_in = {step_resolution_select_i, current_fwd_i, current_target_threshold_i,
                   thermal_shutdown_i, overcurrent_shutdown_i};

  cdf_sync #(.W(7)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(raw_in),
    .sync_o(syn_in)
  );

  logic [2:0] step_sel;
  logic fwd, at_target, thermal_shutdown, overcurrent_shutdown;
  assign step_sel = syn_in[6:4];
  assign fwd = syn_in[3];
  assign at_target = syn_in[2];
  assign thermal_shutdown = syn_in[1];
  assign overcurrent_shutdown = syn_in[0];

  logic standby;
  assign standby = (step_sel == cdf_pkg::STEP_RES_STANDBY);

  // ----------------------------------------------------------------
  // shutdown latches
  // ----------------------------------------------------------------
  logic tsd_lat_r, tsd_lat_nxt, isd_lat_r, isd_lat_nxt;

  // a detection in the same cycle as a standby clear still latches
  always_comb begin
    tsd_lat_nxt = tsd_lat_r;
    isd_lat_nxt = isd_lat_r;
    if (standby) begin
      tsd_lat_nxt = 1'b0;
      isd_lat_nxt = 1'b0;
    end
    if (thermal_shutdown) begin
      tsd_lat_nxt = 1'b1;
    end
    if (overcurrent_shutdown) begin
      isd_lat_nxt = 1'b1;
    end
  end

  logic fault;
  assign fault = tsd_lat_r || isd_lat_r;

  // ----------------------------------------------------------------
  // chopping period
  // ----------------------------------------------------------------
  logic run;
  logic [cdf_pkg::CNT_W-1:0] cnt;
  logic wrap;
  // oscillator stops in standby and while a shutdown is latched
  assign run = !standby && !fault;

  cdf_period u_period (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(run),
    .cnt_o(cnt),
    .wrap_o(wrap)
  );

  // ----------------------------------------------------------------
  // decay state machine
  // ----------------------------------------------------------------
  cdf_pkg::cdf_mode_t mode_r, mode_nxt;
  logic [cdf_pkg::CNT_W-1:0] decay_cnt_r, decay_cnt_nxt;

  always_comb begin
    mode_nxt = mode_r;
    decay_cnt_nxt = decay_cnt_r;
    if (!run) begin
      mode_nxt = cdf_pkg::CDF_MODE_OFF;
      decay_cnt_nxt = cdf_pkg::CNT_ZERO;
    end else begin
      case (mode_r)
        cdf_pkg::CDF_MODE_OFF: begin
          mode_nxt = cdf_pkg::CDF_MODE_CHARGE;
        end
        cdf_pkg::CDF_MODE_CHARGE: begin
          // stays here past the period end until target is reached
          if (at_target) begin
            mode_nxt = cdf_pkg::CDF_MODE_FAST;
            decay_cnt_nxt = cdf_pkg::CNT_ZERO;
          end
        end
        cdf_pkg::CDF_MODE_FAST: begin
          decay_cnt_nxt = decay_cnt_r + 4'h1;
          if (wrap) begin
            mode_nxt = cdf_pkg::CDF_MODE_CHARGE;
          end else if (decay_cnt_r == cdf_pkg::MIXED_DECAY_FAST_SLOTS - 4'h1) begin
            mode_nxt = cdf_pkg::CDF_MODE_SLOW;
          end
        end
        cdf_pkg::CDF_MODE_SLOW: begin
          if (wrap) begin
            mode_nxt = cdf_pkg::CDF_MODE_CHARGE;
          end
        end
        default: begin
          mode_nxt = cdf_pkg::CDF_MODE_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bridge drive with break-before-make
  // ----------------------------------------------------------------
  logic [3:0] sw_r, sw_nxt, target_sw;
  logic flag_r, flag_nxt;

  // a pattern change passes through all-off for one cycle so no leg shoots through
  always_comb begin
    flag_nxt = tsd_lat_nxt || isd_lat_nxt;
    target_sw = cdf_pkg::cdf_pattern(mode_nxt, fwd);
    // a fresh detection drops the bridge on the same edge that latches it
    if (!run || flag_nxt) begin
      sw_nxt = cdf_pkg::SW_OFF;
    end else if (sw_r != target_sw && sw_r != cdf_pkg::SW_OFF) begin
      sw_nxt = cdf_pkg::SW_OFF;
    end else begin
      sw_nxt = target_sw;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsd_lat_r <= 1'b0;
      isd_lat_r <= 1'b0;
      mode_r <= cdf_pkg::CDF_MODE_OFF;
      decay_cnt_r <= cdf_pkg::CNT_ZERO;
      sw_r <= cdf_pkg::SW_OFF;
      flag_r <= 1'b0;
    end else if (ce_i) begin
      tsd_lat_r <= tsd_lat_nxt;
      isd_lat_r <= isd_lat_nxt;
      mode_r <= mode_nxt;
      decay_cnt_r <= decay_cnt_nxt;
      sw_r <= sw_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign high_side_first_o = sw_r[3];
  assign high_side_second_o = sw_r[2];
  assign low_side_first_o = sw_r[1];
  assign low_side_second_o = sw_r[0];
  // pin level is always low; only the enable moves, so it never drives high
  assign fault_flag_out_o = 1'b0;
  assign fault_flag_out_oe_n_o = !flag_r;
  assign mode_o = mode_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence fault_seen_s;
    ce_i && (thermal_shutdown || overcurrent_shutdown);
  endsequence

  sequence flag_low_s;
    !fault_flag_out_oe_n_o;
  endsequence

  fault_pulls_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_seen_s |=> flag_low_s)
    else $error("fault flag not pulled low after shutdown");

  flag_never_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_flag_out_o == 1'b0)
    else $error("fault flag driven high");

  flag_tracks_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_flag_out_oe_n_o == !(tsd_lat_r || isd_lat_r))
    else $error("fault flag differs from shutdown latch");

  period_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wrap) ##1 (ce_i && run) [*8] |-> cnt == 4'h7)
    else $error("chopping period count wrong");

  charge_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && run && mode_r == cdf_pkg::CDF_MODE_CHARGE && !at_target)
      |=> mode_r == cdf_pkg::CDF_MODE_CHARGE)
    else $error("charge left before target reached");

  charge_ends_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && run && mode_r == cdf_pkg::CDF_MODE_CHARGE && at_target)
      |=> mode_r == cdf_pkg::CDF_MODE_FAST)
    else $error("charge did not end at target");

  no_shoot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(sw_r[3] && sw_r[1]) && !(sw_r[2] && sw_r[0]))
    else $error("leg shoot-through");

  standby_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && standby) |=> (sw_r == cdf_pkg::SW_OFF && cnt == cdf_pkg::CNT_ZERO))
    else $error("standby did not stop bridge");

  latch_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fault |-> sw_r == cdf_pkg::SW_OFF)
    else $error("bridge on during shutdown");

  slow_pattern_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && run && mode_r == cdf_pkg::CDF_MODE_SLOW && $stable(mode_r) && $stable(fwd))
      |-> sw_r == cdf_pkg::SW_SLOW)
    else $error("slow decay pattern wrong");
endmodule : cdf_chopper
`default_nettype wire

/* File: tb/cdf_coil_model.sv */
// coil, sense comparator and fault flag pull-up on the bridge side
`timescale 1ns/1ps
`default_nettype none
module cdf_coil_model (
  input wire logic clk_i,
  input wire logic [3:0] sw_i,
  input wire logic dir_i,
  input wire logic [7:0] target_i,
  input wire logic hold_low_i,
  input wire logic flag_i,
  input wire logic flag_oe_n_i,
  output wire logic cmp_o,
  output wire logic flag_wire_o
);
  int cur = 0;
  // the pin is only ever sunk, so the pull-up sets the released level
  assign flag_wire_o = flag_oe_n_i ? 1'b1 : flag_i;
  // a stalled coil is modelled by holding the comparator below target
  assign cmp_o = !hold_low_i && (cur >= int'(target_i));
  always @(posedge clk_i) begin
    if (sw_i == (dir_i ? 4'h9 : 4'h6)) begin
      cur <= cur + 8;
    end else if (sw_i == (dir_i ? 4'h6 : 4'h9)) begin
      cur <= (cur > 3) ? cur - 3 : 0;
    end else if (cur > 0) begin
      cur <= cur - 1;
    end
  end
endmodule : cdf_coil_model
`default_nettype wire

/* File: tb/chopper_decay_fault_control_tb.sv */
// self-checking bench for the chopper decay and fault block
`timescale 1ns/1ps
`default_nettype none
module chopper_decay_fault_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] sel = 3'h0;
  logic fwd = 1'b1;
  logic thermal_shutdown = 1'b0;
  logic ocd = 1'b0;
  logic hold = 1'b1;
  logic watch = 1'b0;
  logic [7:0] tgt = 8'h28;
  wire logic hs1, hs2, ls1, ls2, flag, oe_n, cmp, flag_w;
  wire logic [1:0] mode;
  wire logic [3:0] sw = {hs1, hs2, ls1, ls2};
  logic [3:0] q_sw[$];
  logic q_flag[$];
  int q_per[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int last_chg = 0;
  int fast_run = 0;
  logic [3:0] sw_q = 4'h0;
  logic [3:0] seen = 4'h0;
  logic flag_q = 1'b1;
  logic [1:0] mode_q = 2'h0;

  initial forever #2 clk_i = ~clk_i;

  cdf_chopper u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .step_resolution_select_i(sel),
    .current_fwd_i(fwd), .current_target_threshold_i(cmp), .thermal_shutdown_i(thermal_shutdown),
    .overcurrent_shutdown_i(ocd), .high_side_first_o(hs1), .high_side_second_o(hs2),
    .low_side_first_o(ls1), .low_side_second_o(ls2), .fault_flag_out_o(flag),
    .fault_flag_out_oe_n_o(oe_n), .mode_o(mode));

  cdf_coil_model u_coil (.clk_i(clk_i), .sw_i(sw), .dir_i(fwd), .target_i(tgt), .hold_low_i(hold),
    .flag_i(flag), .flag_oe_n_i(oe_n), .cmp_o(cmp), .flag_wire_o(flag_w));

  task automatic note(input bit bad, input string what, input int e, input int g);
    tests_run++;
    if (bad) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", what, e, g);
    end
  endtask : note
  task automatic cmp_sw(input string what, input logic [3:0] e, input logic [3:0] g);
    note(g !== e, what, e, g);
  endtask : cmp_sw
  task automatic cmp_bit(input string what, input logic e, input logic g);
    note(g !== e, what, e, g);
  endtask : cmp_bit
  task automatic cmp_cnt(input string what, input int e, input int g);
    note(g != e, what, e, g);
  endtask : cmp_cnt
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // ----------------------------------------
  // monitor
  // ----------------------------------------
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
    if (!rst_i) begin
      cmp_bit("shoot through", 1'b0, (hs1 & ls1) | (hs2 & ls2));
      if (oe_n === 1'b0) cmp_bit("driven level", 1'b0, flag);
      if (flag_w !== flag_q) cmp_bit("fault flag", q_flag.size() ? q_flag.pop_front() : flag_q, flag_w);
      if (sw != sw_q && sw != 4'h0) begin
        cmp_bit("pattern set", 1'b1, sw inside {4'h9, 4'h6, 4'h3});
        if (watch) cmp_sw("bridge", q_sw.size() ? q_sw.pop_front() : 4'h0, sw);
      end
      seen = seen | (4'h1 << mode);
      fast_run = (mode == 2'h3) ? fast_run + 1 : 0;
      // a fast run is only whole when charge ended early in the period
      if (mode_q == 2'h3 && mode == 2'h2 && q_per.size() > 0) begin
        cmp_cnt("fast run", cdf_pkg::MIXED_DECAY_FAST_SLOTS, fast_run_q(mode));
      end
      if (mode == 2'h1 && mode_q == 2'h2) begin
        if (q_per.size() > 0) cmp_cnt("period", q_per.pop_front(), cyc - last_chg);
        last_chg = cyc;
      end
    end
    sw_q = sw;
    flag_q = flag_w;
    mode_q = mode;
  end
  int fast_len = 0;
  always @(posedge clk_i) fast_len <= (mode == 2'h3) ? fast_len + 1 : 0;
  function automatic int fast_run_q(input logic [1:0] m);
    return fast_len;
  endfunction : fast_run_q

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1BD8));
    step(20);
    rst_i = 1'b0;
    for (int d = 1; d >= 0; d--) begin
      fwd = d[0];
      hold = 1'b1;
      sel = 3'($urandom_range(7, 1));
      watch = 1'b1;
      q_sw.push_back(d ? 4'h9 : 4'h6);
      step(60);
      cmp_bit("charge held", 1'b1, mode === 2'h1);
      q_sw.push_back(d ? 4'h6 : 4'h9);
      hold = 1'b0;
      tgt = 8'h00;
      step(9);
      watch = 1'b0;
      cmp_cnt("bridge pending", 0, q_sw.size());
      sel = 3'h0;
      step(8);
      cmp_sw("standby bridge", 4'h0, sw);
      cmp_bit("standby mode", 1'b1, mode === 2'h0);
    end
    fwd = 1'($urandom);
    tgt = 8'($urandom_range(200, 20));
    sel = 3'($urandom_range(7, 1));
    seen = 4'h0;
    step(80);
    for (int i = 0; i < 6; i++) q_per.push_back(16);
    step(120);
    cmp_cnt("periods pending", 0, q_per.size());
    cmp_sw("modes seen", 4'hE, seen & 4'hE);
    for (int k = 0; k < 3; k++) begin
      q_flag.push_back(1'b0);
      if (k == 0) thermal_shutdown = 1'b1;
      else ocd = 1'b1;
      step(3);
      thermal_shutdown = 1'b0;
      ocd = 1'b0;
      step(30);
      cmp_sw("latched off", 4'h0, sw);
      cmp_bit("flag held", 1'b0, flag_w);
      if (k < 2) begin
        q_flag.push_back(1'b1);
        sel = 3'h0;
        step(8);
        cmp_cnt("flag pending", 0, q_flag.size());
        sel = 3'($urandom_range(7, 1));
      end else begin
        rst_i = 1'b1;
        step(2);
        rst_i = 1'b0;
        cmp_bit("flag after reset", 1'b1, flag_w);
      end
      step(30);
      cmp_bit("restart", 1'b1, sw != 4'h0);
    end
    finish_test();
  end
endmodule : chopper_decay_fault_control_tb
`default_nettype wire
